// file: shared/ddr3_wsr_defines.svh
/*
 * Offsets, field positions, reset values and counts for the DDR3 write,
 * precharge and self refresh device core.
 * Assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`ifndef DDR3_WSR_DEFINES_SVH
`define DDR3_WSR_DEFINES_SVH

`define OFS_CTRL        4'h0
`define OFS_STATUS      4'h4
`define OFS_MEM_SEL     4'h8
`define OFS_MEM_DATA    4'hc
`define OFS_WR_COUNT    4'h0

`define CTRL_BL_LSB     0
`define CTRL_AL_LSB     4
`define CTRL_CWL_LSB    8
`define CTRL_RESET      32'h0000_0500

`define BL_FIXED8       2'h0
`define BL_OTF          2'h1
`define BL_FIXED4       2'h2

`define ST_SR_BIT       8
`define ST_DLL_EN_BIT   9
`define ST_DLL_LOCK_BIT 10
`define ST_BUSY_BIT     11
`define ST_REF_LSB      16

`define DLL_LOCK_CK     10'h200
`define LINE_DEPTH      32
`define BEATS_BL8       4'h8
`define BEATS_BC4       4'h4

`endif

// file: shared/ddr3_wsr_pkg.sv
/*
 * Types for the DDR3 write, precharge and self refresh device core.
 * Assumes nothing beyond the defines header for constants.
 */
package ddr3_wsr_pkg;

	typedef enum logic [3:0] {
		CMD_MRS = 4'h0,
		CMD_REF = 4'h1,
		CMD_PRE = 4'h2,
		CMD_ACT = 4'h3,
		CMD_WR  = 4'h4
	} cmd_e;

	typedef struct packed {
		logic       valid;
		logic [2:0] bank;
		logic [2:0] col;
		logic       bc4;
		logic       ap;
	} slot_s;

	typedef logic [31:0] word_t;

endpackage

// file: src/ddr3_wsr_dev.sv
/*
 * Device-side core of a DDR3 part: WRITE bursts, PRECHARGE and self refresh,
 * with a small data store and an Avalon-MM register slave.
 * Assumes every DDR3 pin is asynchronous to CLK_IN and changes far slower than
 * CLK_IN (CK about 160 ns), so two-flop sampling and edge detection suffice.
 */
// How it works
// RULE1: BL8 when burst mode is 00, or 01 with A12 high at WRITE.
// RULE2: Burst mode 01 with A12 low gives a four-beat chopped write.
// RULE3: Burst mode 10 chops every access to four beats whatever A12 holds.
// RULE4: Controller starts recovery intervals two clocks earlier for fixed chop.
// RULE5: Controller counts write-to-read from first clock after last beat.
// RULE6: Controller counts on-the-fly chop write-to-read as if eight beats passed.
// RULE7: Controller waits write recovery after last beat before precharging that bank.
// RULE8: Each WRITE, back to back or spaced, may target any bank.
// RULE9: Controller drives strobe high, then low half a clock before data.
// RULE10: Controller keeps strobe low a half clock after the last beat.
// RULE11: PRECHARGE with A10 high closes all banks, else the bank on BA.
// RULE12: All-bank precharge ignores BA; idle banks refuse WRITE until activated.
// RULE13: REFRESH with clock enable low enters self refresh.
// RULE14: DLL turns off on self refresh entry, restarts and relocks on exit.
// RULE15: Controller delays first WRITE 512 clocks after floating reference returns.
// RULE16: Controller enters self refresh only with all banks idle and no burst.
// RULE17: Controller registers ODT low before entry unless termination is disabled.
// RULE18: In self refresh only clock enable and reset pin are heeded.
// RULE19: Device performs an internal refresh at once on self refresh entry.
// RULE20: With steady clock, controller may exit after minimum residency.
// RULE21: With altered clock, controller honours entry and exit clock intervals.
// RULE22: Controller issues only NOP or deselect for exit time after exit.
// RULE23: Controller does long calibration and waits DLL time before DLL commands.
// RULE24: Write latency is additive plus CAS write latency, fixing first beat.
// RULE25: A beat with the data mask high is not stored.
// RULE26: Controller keeps its intervals as cycle counts rounded up from ns.
`timescale 1ns/1ps
`include "ddr3_wsr_defines.svh"

module ddr3_wsr_dev (
	// System
	input  wire logic                 CLK_IN,
	input  wire logic                 RST_IN,
	// Avalon-MM slave
	input  wire logic [3:0]           AVS_ADDRESS_IN,
	input  wire logic                 AVS_READ_IN,
	input  wire logic                 AVS_WRITE_IN,
	input  wire logic [3:0]           AVS_BYTEENABLE_IN,
	input  wire ddr3_wsr_pkg::word_t  AVS_WRITEDATA_IN,
	output ddr3_wsr_pkg::word_t       AVS_READDATA_OUT,
	output logic                      AVS_WAITREQUEST_OUT,
	// DDR3 command pins
	input  wire logic                 CK_IN,
	input  wire logic                 CKE_IN,
	input  wire logic                 CS_N_IN,
	input  wire logic                 RAS_N_IN,
	input  wire logic                 CAS_N_IN,
	input  wire logic                 WE_N_IN,
	input  wire logic [13:0]          ADDR_IN,
	input  wire logic [2:0]           BA_IN,
	input  wire logic                 ODT_IN,
	input  wire logic                 RESET_N_IN,
	// DDR3 write data pins
	input  wire logic                 DQS_IN,
	input  wire logic [7:0]           DQ_IN,
	input  wire logic                 DM_IN,
	// Status
	output logic                      SELF_REFRESH_OUT,
	output logic                      DLL_ENABLE_OUT
);
	import ddr3_wsr_pkg::*;

	// Two-flop sampling of every DDR3 pin; ODT is sampled for completeness only.
	localparam int PW = 35;
	logic [PW-1:0] pin_raw;
	logic [PW-1:0] sync1_ff;
	logic [PW-1:0] sync2_ff;
	logic          ck_prev_ff;
	logic          dqs_prev_ff;

	assign pin_raw = {CK_IN, CKE_IN, CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN, ADDR_IN, BA_IN,
		ODT_IN, RESET_N_IN, DQS_IN, DQ_IN, DM_IN};

	always_ff @(posedge CLK_IN) begin
		sync1_ff    <= pin_raw;
		sync2_ff    <= sync1_ff;
		ck_prev_ff  <= sync2_ff[34];
		dqs_prev_ff <= sync2_ff[9];
	end

	logic        ck_s;
	logic        cke_s;
	logic [3:0]  cmd_s;
	logic [13:0] addr_s;
	logic [2:0]  ba_s;
	logic        rstn_s;
	logic        dqs_s;
	logic [7:0]  dq_s;
	logic        dm_s;
	logic        ck_rise;
	logic        dqs_edge;
	logic        dqs_rise;

	assign ck_s     = sync2_ff[34];
	assign cke_s    = sync2_ff[33];
	assign cmd_s    = sync2_ff[32:29];
	assign addr_s   = sync2_ff[28:15];
	assign ba_s     = sync2_ff[14:12];
	assign rstn_s   = sync2_ff[10];
	assign dqs_s    = sync2_ff[9];
	assign dq_s     = sync2_ff[8:1];
	assign dm_s     = sync2_ff[0];
	assign ck_rise  = ck_s & ~ck_prev_ff;
	assign dqs_edge = dqs_s ^ dqs_prev_ff;
	assign dqs_rise = dqs_s & ~dqs_prev_ff;

	// Register file state.
	word_t      ctrl_ff;
	logic [5:0] sel_ff;
	word_t      nxt_ctrl;
	logic [5:0] nxt_sel;

	// Device state.
	logic [7:0]  bank_open_ff;
	logic        sr_ff;
	logic        dll_en_ff;
	logic        dll_lock_ff;
	logic [9:0]  dll_cnt_ff;
	logic [7:0]  ref_cnt_ff;
	logic [15:0] wcnt_ff;
	slot_s       line_ff [`LINE_DEPTH];
	slot_s       armed_ff;
	slot_s       act_ff;
	logic [2:0]  beat_ff;
	logic [3:0]  left_ff;
	logic [7:0]  mem_ff [64];

	logic [7:0]  nxt_bank_open;
	logic        nxt_sr;
	logic        nxt_dll_en;
	logic        nxt_dll_lock;
	logic [9:0]  nxt_dll_cnt;
	logic [7:0]  nxt_ref_cnt;
	logic [15:0] nxt_wcnt;
	slot_s       nxt_line [`LINE_DEPTH];
	slot_s       nxt_armed;
	slot_s       nxt_act;
	logic [2:0]  nxt_beat;
	logic [3:0]  nxt_left;
	logic        mem_we;
	logic [5:0]  mem_idx;

	logic [1:0]  bl_mode;
	logic [4:0]  wl;
	logic [4:0]  ins_pos;
	logic        wr_bc4;
	slot_s       beat_src;
	logic        beat_go;

	assign bl_mode = ctrl_ff[`CTRL_BL_LSB +: 2];
	assign wl      = {1'b0, ctrl_ff[`CTRL_AL_LSB +: 4]} + {1'b0, ctrl_ff[`CTRL_CWL_LSB +: 4]}; // RULE24
	// Armed at the clock before WL so a strobe leading the clock by a quarter period is not missed.
	assign ins_pos = (wl < 5'h2) ? 5'h0 : wl - 5'h2;

	always_comb begin
		unique case (bl_mode)
			`BL_OTF:    wr_bc4 = ~addr_s[12]; // RULE1 RULE2
			`BL_FIXED4: wr_bc4 = 1'b1;        // RULE3
			default:    wr_bc4 = 1'b0;        // RULE1
		endcase
	end

	always_comb begin
		nxt_bank_open = bank_open_ff;
		nxt_sr        = sr_ff;
		nxt_dll_en    = dll_en_ff;
		nxt_dll_lock  = dll_lock_ff;
		nxt_dll_cnt   = dll_cnt_ff;
		nxt_ref_cnt   = ref_cnt_ff;
		nxt_wcnt      = wcnt_ff;
		nxt_line      = line_ff;
		nxt_armed     = armed_ff;
		nxt_act       = act_ff;
		nxt_beat      = beat_ff;
		nxt_left      = left_ff;
		mem_we        = 1'b0;
		mem_idx       = 6'h0;
		beat_go       = 1'b0;
		beat_src      = act_ff;

		// Data beats ride on every strobe edge; a new burst only starts on a rising edge,
		// so the preamble and postamble low levels are never taken as data.
		if (dqs_edge && left_ff != 4'h0) begin
			beat_go  = 1'b1;
			nxt_left = left_ff - 4'h1;
			nxt_beat = beat_ff + 3'h1;
		end else if (dqs_rise && armed_ff.valid) begin // RULE9 RULE10
			beat_go   = 1'b1;
			beat_src  = armed_ff;
			nxt_act   = armed_ff;
			nxt_armed = '0;
			nxt_left  = (armed_ff.bc4 ? `BEATS_BC4 : `BEATS_BL8) - 4'h1;
			nxt_beat  = armed_ff.col + 3'h1;
		end
		if (beat_go) begin
			mem_idx = {beat_src.bank, (left_ff != 4'h0) ? beat_ff : beat_src.col};
			mem_we  = ~dm_s; // RULE25
			if (!dm_s) begin
				nxt_wcnt = wcnt_ff + 16'h1;
			end
			if (nxt_left == 4'h0 && beat_src.ap) begin
				nxt_bank_open[beat_src.bank] = 1'b0;
			end
		end

		if (ck_rise) begin
			for (int i = 0; i < `LINE_DEPTH - 1; i++) begin
				nxt_line[i] = line_ff[i + 1];
			end
			nxt_line[`LINE_DEPTH - 1] = '0;
			if (line_ff[0].valid) begin
				nxt_armed = line_ff[0]; // RULE24
			end
			if (dll_en_ff && !dll_lock_ff) begin
				nxt_dll_cnt = dll_cnt_ff + 10'h1;
				if (dll_cnt_ff == `DLL_LOCK_CK - 10'h1) begin
					nxt_dll_lock = 1'b1; // RULE14
				end
			end
			if (!sr_ff && cmd_s[3] == 1'b0) begin // RULE18
				unique case (cmd_e'(cmd_s))
					CMD_ACT: nxt_bank_open[ba_s] = 1'b1;
					CMD_PRE: begin
						if (addr_s[10]) begin
							nxt_bank_open = 8'h00; // RULE11 RULE12
						end else begin
							nxt_bank_open[ba_s] = 1'b0; // RULE11
						end
					end
					CMD_WR: begin
						if (bank_open_ff[ba_s]) begin // RULE8 RULE12
							nxt_line[ins_pos] = '{valid: 1'b1, bank: ba_s, col: addr_s[2:0],
								bc4: wr_bc4, ap: addr_s[10]};
						end
					end
					CMD_REF: begin
						if (!cke_s) begin // RULE13 RULE16
							nxt_sr       = 1'b1;
							nxt_dll_en   = 1'b0; // RULE14
							nxt_dll_lock = 1'b0;
							nxt_ref_cnt  = ref_cnt_ff + 8'h1; // RULE19
						end else begin
							nxt_ref_cnt  = ref_cnt_ff + 8'h1;
						end
					end
					default: ;
				endcase
			end
		end

		// Exit is asynchronous to CK, which may be stopped while the part sleeps.
		if (sr_ff && cke_s) begin
			nxt_sr      = 1'b0;
			nxt_dll_en  = 1'b1; // RULE14
			nxt_dll_cnt = 10'h0;
		end

		if (!rstn_s) begin // RULE18
			nxt_bank_open = 8'h00;
			nxt_sr        = 1'b0;
			nxt_dll_en    = 1'b1;
			nxt_dll_lock  = 1'b0;
			nxt_dll_cnt   = 10'h0;
			nxt_armed     = '0;
			nxt_act       = '0;
			nxt_left      = 4'h0;
			for (int i = 0; i < `LINE_DEPTH; i++) begin
				nxt_line[i] = '0;
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			bank_open_ff <= 8'h00;
			sr_ff        <= 1'b0;
			dll_en_ff    <= 1'b1;
			dll_lock_ff  <= 1'b0;
			dll_cnt_ff   <= 10'h0;
			ref_cnt_ff   <= 8'h00;
			wcnt_ff      <= 16'h0000;
			armed_ff     <= '0;
			act_ff       <= '0;
			beat_ff      <= 3'h0;
			left_ff      <= 4'h0;
			for (int i = 0; i < `LINE_DEPTH; i++) begin
				line_ff[i] <= '0;
			end
		end else begin
			bank_open_ff <= nxt_bank_open;
			sr_ff        <= nxt_sr;
			dll_en_ff    <= nxt_dll_en;
			dll_lock_ff  <= nxt_dll_lock;
			dll_cnt_ff   <= nxt_dll_cnt;
			ref_cnt_ff   <= nxt_ref_cnt;
			wcnt_ff      <= nxt_wcnt;
			armed_ff     <= nxt_armed;
			act_ff       <= nxt_act;
			beat_ff      <= nxt_beat;
			left_ff      <= nxt_left;
			line_ff      <= nxt_line;
		end
	end

	// The store keeps its contents through reset, as the array of a real part would.
	always_ff @(posedge CLK_IN) begin
		if (mem_we) begin
			mem_ff[mem_idx] <= dq_s;
		end
	end

	// Avalon slave: every access waits exactly one cycle, then completes.
	logic  wait_ff;
	logic  nxt_wait;
	word_t rdata_ff;
	word_t nxt_rdata;
	word_t status;
	word_t be_mask;
	logic  req;

	assign req     = AVS_READ_IN | AVS_WRITE_IN;
	assign be_mask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
		{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
	assign status  = {8'h00, ref_cnt_ff, 4'h0, (left_ff != 4'h0) | armed_ff.valid, dll_lock_ff,
		dll_en_ff, sr_ff, bank_open_ff};

	always_comb begin
		nxt_wait  = 1'b1;
		nxt_rdata = rdata_ff;
		nxt_ctrl  = ctrl_ff;
		nxt_sel   = sel_ff;
		if (req && wait_ff) begin
			nxt_wait = 1'b0;
			if (AVS_READ_IN) begin
				unique case (AVS_ADDRESS_IN)
					`OFS_CTRL:     nxt_rdata = ctrl_ff;
					`OFS_STATUS:   nxt_rdata = status;
					`OFS_MEM_SEL:  nxt_rdata = {26'h0, sel_ff};
					`OFS_MEM_DATA: nxt_rdata = {24'h0, mem_ff[sel_ff]};
					default:       nxt_rdata = {16'h0, wcnt_ff};
				endcase
				if (AVS_ADDRESS_IN[1:0] != 2'h0) begin
					nxt_rdata = 32'h0;
				end
			end
		end
		// A write lands only at the edge that completes it, so an early abort changes nothing.
		if (AVS_WRITE_IN && !wait_ff) begin
			if (AVS_ADDRESS_IN == `OFS_CTRL) begin
				nxt_ctrl = ((ctrl_ff & ~be_mask) | (AVS_WRITEDATA_IN & be_mask)) & 32'h0000_0ff3;
			end else if (AVS_ADDRESS_IN == `OFS_MEM_SEL && AVS_BYTEENABLE_IN[0]) begin
				nxt_sel = AVS_WRITEDATA_IN[5:0];
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			wait_ff  <= 1'b1;
			rdata_ff <= 32'h0;
			ctrl_ff  <= `CTRL_RESET;
			sel_ff   <= 6'h0;
		end else begin
			wait_ff  <= nxt_wait;
			rdata_ff <= nxt_rdata;
			ctrl_ff  <= nxt_ctrl;
			sel_ff   <= nxt_sel;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			SELF_REFRESH_OUT <= 1'b0;
			DLL_ENABLE_OUT   <= 1'b1;
		end else begin
			SELF_REFRESH_OUT <= nxt_sr;
			DLL_ENABLE_OUT   <= nxt_dll_en;
		end
	end

	assign AVS_READDATA_OUT    = rdata_ff;
	assign AVS_WAITREQUEST_OUT = wait_ff;

endmodule

// file: verif/ddr3_wsr_dev_props.sv
/* Port checker for the DDR3 device core.
   Assumes it is bound to every instance of ddr3_wsr_dev. */
`timescale 1ns/1ps
module ddr3_wsr_dev_props (
	// System
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// Avalon-MM slave
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic AVS_WAITREQUEST_OUT,
	// DDR3 pins and status
	input wire logic CKE_IN,
	input wire logic RESET_N_IN,
	input wire logic SELF_REFRESH_OUT,
	input wire logic DLL_ENABLE_OUT
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);
	property p_wait_answer;
		(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT;
	endproperty
	a_wait_answer: assert property (p_wait_answer) else $error("access not answered");
	property p_wait_one;
		!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
	property p_wait_cause;
		$fell(AVS_WAITREQUEST_OUT) |-> $past(AVS_READ_IN || AVS_WRITE_IN);
	endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
	property p_reset_vals;
		$fell(RST_IN) |-> AVS_WAITREQUEST_OUT && DLL_ENABLE_OUT && !SELF_REFRESH_OUT;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");
	property p_sr_dll;
		SELF_REFRESH_OUT |-> !DLL_ENABLE_OUT;
	endproperty
	a_sr_dll: assert property (p_sr_dll) else $error("dll on in self refresh");
	property p_exit_dll;
		$fell(SELF_REFRESH_OUT) |-> DLL_ENABLE_OUT;
	endproperty
	a_exit_dll: assert property (p_exit_dll) else $error("dll off after exit");
	property p_sr_entry;
		$rose(SELF_REFRESH_OUT) |-> !CKE_IN && $past(!CKE_IN, 2);
	endproperty
	a_sr_entry: assert property (p_sr_entry) else $error("entry with clock enable high");
	property p_sr_stay;
		SELF_REFRESH_OUT && !CKE_IN && $past(!CKE_IN, 3) && RESET_N_IN && $past(RESET_N_IN, 3)
			|=> SELF_REFRESH_OUT;
	endproperty
	a_sr_stay: assert property (p_sr_stay) else $error("left self refresh early");
	property p_sr_exit;
		SELF_REFRESH_OUT && CKE_IN |-> ##[1:5] !SELF_REFRESH_OUT;
	endproperty
	a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit late");
endmodule
bind ddr3_wsr_dev ddr3_wsr_dev_props i_ddr3_wsr_dev_props (
	.CLK_IN, .RST_IN, .AVS_READ_IN, .AVS_WRITE_IN, .AVS_WAITREQUEST_OUT,
	.CKE_IN, .RESET_N_IN, .SELF_REFRESH_OUT, .DLL_ENABLE_OUT
);

// file: verif/ddr3_host.sv
/* Behavioural memory controller driving the DDR3 pins.
   Assumes one task call at a time and termination disabled. */
`timescale 1ns/1ps
module ddr3_host (
	// Clock and command
	output logic        ck_out,
	output logic        cke_out,
	output logic        cs_n_out,
	output logic        ras_n_out,
	output logic        cas_n_out,
	output logic        we_n_out,
	output logic [13:0] addr_out,
	output logic [2:0]  ba_out,
	output logic        odt_out,
	output logic        reset_n_out,
	// Write data
	output logic        dqs_out,
	output logic [7:0]  dq_out,
	output logic        dm_out
);
	initial begin
		{cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out, reset_n_out, dqs_out} = 7'h7f;
		{odt_out, dm_out, addr_out, ba_out, dq_out} = '0;
		ck_out = 1'b0;
		#3.3;
		forever
			#80 ck_out = ~ck_out;
	end
	// Pins change on the falling edge so they are settled around the rising edge.
	task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a, input logic e);
		@(negedge ck_out);
		{cs_n_out, ras_n_out, cas_n_out, we_n_out, cke_out} = {1'b0, c, e};
		ba_out = b;
		addr_out = a;
		@(negedge ck_out);
		cs_n_out = 1'b1;
		addr_out = ~addr_out;
		ba_out = ~ba_out;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ck_out);
	endtask
	task automatic pin_reset(input logic v);
		@(negedge ck_out);
		reset_n_out = v;
	endtask
	task automatic wr(input logic [2:0] b, input logic [13:0] a, input int w, input int n,
		input logic [63:0] d, input logic [7:0] m);
		cmd(3'h4, b, a, 1'b1);
		repeat (w - 1) @(negedge ck_out);
		dqs_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			#40 {dq_out, dm_out} = {d[8*i +: 8], m[i]};
			#40 dqs_out = ~dqs_out;
		end
		#80 dqs_out = 1'b1;
		dq_out = ~dq_out;
	endtask
endmodule

// file: verif/ddr3_wsr_dev_tb.sv
/* Self-checking bench for the DDR3 device core.
   Assumes the checker is bound and the host model drives the DDR3 pins. */
`timescale 1ns/1ps
`include "ddr3_wsr_defines.svh"
module ddr3_wsr_dev_tb;
	import ddr3_wsr_pkg::*;
	localparam logic [2:0] ACT = 3'h3, PRE = 3'h2, REF = 3'h1, NOP = 3'h7;
	localparam word_t MK = 32'h00ff_0bff;
	logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
	logic [3:0]  adr = 4'h0;
	word_t       wdat = 32'h0, rdat, exp_q[$], msk_q[$];
	logic        wait_o, sr, dll, ck, cke, cs_n, ras_n, cas_n, we_n, odt, reset_n, dqs, dm;
	logic [13:0] addr;
	logic [2:0]  ba;
	logic [7:0]  dq, mem[64];
	int          n_fail = 0, n_compared = 0, seed = 93, cyc = 0;
	word_t       ctl[5] = '{32'h500, 32'h501, 32'h511, 32'h602, 32'h503};
	int          wl[5] = '{5, 5, 6, 6, 5}, ln[5] = '{8, 8, 4, 4, 8};
	logic        hi[5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
	logic [2:0]  cl[5] = '{3'h3, 3'h0, 3'h5, 3'h1, 3'h7};
	ddr3_wsr_dev i_ddr3_wsr_dev (.CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
		.AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(4'hf), .AVS_WRITEDATA_IN(wdat), .AVS_READDATA_OUT(rdat),
		.AVS_WAITREQUEST_OUT(wait_o), .CK_IN(ck), .CKE_IN(cke), .CS_N_IN(cs_n), .RAS_N_IN(ras_n),
		.CAS_N_IN(cas_n), .WE_N_IN(we_n), .ADDR_IN(addr), .BA_IN(ba), .ODT_IN(odt), .RESET_N_IN(reset_n),
		.DQS_IN(dqs), .DQ_IN(dq), .DM_IN(dm), .SELF_REFRESH_OUT(sr), .DLL_ENABLE_OUT(dll));
	ddr3_host i_ddr3_host (.ck_out(ck), .cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n),
		.cas_n_out(cas_n), .we_n_out(we_n), .addr_out(addr), .ba_out(ba), .odt_out(odt),
		.reset_n_out(reset_n), .dqs_out(dqs), .dq_out(dq), .dm_out(dm));
	always #2.5 clk = ~clk;
	task automatic final_report;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input word_t seen, input word_t exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input word_t d);
		@(posedge clk);
		adr <= a;
		wdat <= d;
		rd <= !w;
		wr <= w;
		do
			@(posedge clk);
		while (wait_o !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic st(input logic [3:0] a, input word_t e, input word_t m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask
	function automatic word_t stw(input logic [7:0] o, input logic s, input logic d, input logic [7:0] c);
		return {8'h0, c, 6'h0, d, s, o};
	endfunction
	task automatic mem_chk(input logic [2:0] b);
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, `OFS_MEM_SEL, {26'h0, b, c[2:0]});
			st(`OFS_MEM_DATA, {24'h0, mem[{b, c[2:0]}]}, 32'hff);
		end
	endtask
	task automatic burst(input logic [2:0] b, input logic [2:0] c, input logic h, input int w, input int n,
		input logic [7:0] m);
		logic [63:0] d;
		d = {$random(seed), $random(seed)};
		i_ddr3_host.wr(b, {1'b0, h, 9'h0, c}, w, n, d, m);
		for (int k = 0; k < n; k++)
			if (!m[k])
				mem[{b, c + k[2:0]}] = d[8*k +: 8];
	endtask
	// Read results are compared against the oldest note, in request order.
	always @(posedge clk) begin
		cyc++;
		if (rd === 1'b1 && wait_o === 1'b0)
			check(rdat & msk_q.pop_front(), exp_q.pop_front());
		if (cyc == 60000) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		st(`OFS_CTRL, `CTRL_RESET, '1);
		st(4'h2, 32'h0, '1);
		bus(1'b1, `OFS_STATUS, '1);
		for (int i = 0; i < 5; i++) begin
			i_ddr3_host.cmd(ACT, i[2:0], 14'h0, 1'b1);
			bus(1'b1, `OFS_CTRL, `CTRL_RESET);
			burst(i[2:0], 3'h0, 1'b0, 5, 8, 8'h0);
			bus(1'b1, `OFS_CTRL, ctl[i]);
			burst(i[2:0], cl[i], hi[i], wl[i], ln[i], 8'($random(seed)));
			i_ddr3_host.idle(4);
			st(`OFS_STATUS, stw((8'h2 << i) - 8'h1, 1'b0, 1'b1, 8'h0), MK);
			mem_chk(i[2:0]);
		end
		i_ddr3_host.cmd(PRE, 3'h1, 14'h0, 1'b1);
		st(`OFS_STATUS, stw(8'h1d, 1'b0, 1'b1, 8'h0), MK);
		i_ddr3_host.wr(3'h1, 14'h0, 5, 8, 64'h0123_4567_89ab_cdef, 8'h0);
		mem_chk(3'h1);
		i_ddr3_host.cmd(PRE, 3'h6, 14'h0400, 1'b1);
		i_ddr3_host.cmd(REF, 3'h0, 14'h0, 1'b1);
		st(`OFS_STATUS, stw(8'h0, 1'b0, 1'b1, 8'h1), MK);
		i_ddr3_host.cmd(REF, 3'h0, 14'h0, 1'b0);
		st(`OFS_STATUS, stw(8'h0, 1'b1, 1'b0, 8'h2), MK);
		check({30'h0, sr, dll}, 32'h2);
		i_ddr3_host.cmd(ACT, 3'h2, 14'h0, 1'b0);
		i_ddr3_host.cmd(REF, 3'h0, 14'h0, 1'b0);
		i_ddr3_host.idle(8);
		st(`OFS_STATUS, stw(8'h0, 1'b1, 1'b0, 8'h2), MK);
		i_ddr3_host.cmd(NOP, 3'h0, 14'h0, 1'b1);
		st(`OFS_STATUS, stw(8'h0, 1'b0, 1'b1, 8'h2), 32'h00ff_0fff);
		check({30'h0, sr, dll}, 32'h1);
		i_ddr3_host.idle(520);
		st(`OFS_STATUS, stw(8'h0, 1'b0, 1'b1, 8'h2) | 32'h400, 32'h00ff_0fff);
		i_ddr3_host.cmd(REF, 3'h0, 14'h0, 1'b0);
		st(`OFS_STATUS, stw(8'h0, 1'b1, 1'b0, 8'h3), 32'h00ff_0fff);
		i_ddr3_host.pin_reset(1'b0);
		i_ddr3_host.idle(2);
		st(`OFS_STATUS, stw(8'h0, 1'b0, 1'b1, 8'h3), 32'h00ff_0fff);
		check({30'h0, sr, dll}, 32'h1);
		i_ddr3_host.pin_reset(1'b1);
		final_report();
	end
endmodule
